// >>> design/slcb_pkg.sv
// Package: command codes, register indices, reset values and timing for the limit command bank
package slcb_pkg;

  // ==========================================================================
  // Geometry
  localparam int unsigned NUM_CHAN = 4;
  localparam int unsigned NUM_CREG = 12;
  localparam int unsigned NUM_VREG = 6;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] CMD_VOUT_FORMAT  = 8'h20;
  localparam logic [7:0] CMD_SETPOINT     = 8'h21;
  localparam logic [7:0] CMD_CEILING      = 8'h24;
  localparam logic [7:0] CMD_MARGIN_HI    = 8'h25;
  localparam logic [7:0] CMD_MARGIN_LO    = 8'h26;
  localparam logic [7:0] CMD_TURN_ON_LVL  = 8'h35;
  localparam logic [7:0] CMD_TURN_OFF_LVL = 8'h36;
  localparam logic [7:0] CMD_VOUT_OV_F    = 8'h40;
  localparam logic [7:0] CMD_VOUT_OV_W    = 8'h42;
  localparam logic [7:0] CMD_VOUT_UV_W    = 8'h43;
  localparam logic [7:0] CMD_VOUT_UV_F    = 8'h44;
  localparam logic [7:0] CMD_VIN_OV_F     = 8'h55;
  localparam logic [7:0] CMD_VIN_OV_W     = 8'h57;
  localparam logic [7:0] CMD_VIN_UV_W     = 8'h58;
  localparam logic [7:0] CMD_VIN_UV_F     = 8'h59;
  localparam logic [7:0] CMD_PG_ON        = 8'h5E;
  localparam logic [7:0] CMD_PG_OFF       = 8'h5F;
  localparam logic [7:0] CMD_DAC          = 8'hE0;
  localparam logic [7:0] CMD_DISCHARGE    = 8'hE9;
  localparam logic [7:0] CMD_SHARED_STAT  = 8'hD1;
  localparam logic [7:0] CMD_NVM_ERASE    = 8'hBD;
  localparam logic [7:0] CMD_NVM_DATA     = 8'hBF;

  // ==========================================================================
  // Field layouts and fixed values
  localparam logic [7:0] VOUT_FORMAT_VAL  = 8'h13;
  localparam logic [7:0] ERASE_KEY        = 8'h2B;
  localparam int unsigned NOT_BUSY_BIT    = 6;
  localparam int unsigned DAC_BITS        = 10;

  // ==========================================================================
  // Per-channel register indices
  localparam logic [3:0] CI_SETPT = 4'h0;
  localparam logic [3:0] CI_CEIL  = 4'h1;
  localparam logic [3:0] CI_MHI   = 4'h2;
  localparam logic [3:0] CI_MLO   = 4'h3;
  localparam logic [3:0] CI_OVF   = 4'h4;
  localparam logic [3:0] CI_OVW   = 4'h5;
  localparam logic [3:0] CI_UVW   = 4'h6;
  localparam logic [3:0] CI_UVF   = 4'h7;
  localparam logic [3:0] CI_PGON  = 4'h8;
  localparam logic [3:0] CI_PGOFF = 4'h9;
  localparam logic [3:0] CI_DISCH = 4'hA;
  localparam logic [3:0] CI_DAC   = 4'hB;

  // Input-voltage register indices
  localparam logic [2:0] VI_ON   = 3'h0;
  localparam logic [2:0] VI_OFF  = 3'h1;
  localparam logic [2:0] VI_OVF  = 3'h2;
  localparam logic [2:0] VI_OVW  = 3'h3;
  localparam logic [2:0] VI_UVW  = 3'h4;
  localparam logic [2:0] VI_UVF  = 3'h5;

  // ==========================================================================
  // Reset values, highest index first
  localparam logic [NUM_CREG-1:0][15:0] CHAN_RESET = {
    16'h0000, 16'hC200, 16'h1E14, 16'h1EB8, 16'h1CCD, 16'h1D9A,
    16'h2266, 16'h2333, 16'h1E66, 16'h219A, 16'h8000, 16'h2000};
  localparam logic [NUM_VREG-1:0][15:0] VIN_RESET = {
    16'h8000, 16'h8000, 16'hD380, 16'hD3C0, 16'hD240, 16'hD280};

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_PERIOD_PS     = 5000;
  localparam int unsigned NVM_WORD_TIME_PS  = 170000000;
  localparam longint unsigned NVM_ERASE_TIME_PS = 64'd400000000000;
  localparam int unsigned NVM_WORD_CYCLES   = (NVM_WORD_TIME_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned NVM_ERASE_CYCLES  =
    32'((NVM_ERASE_TIME_PS + 64'(CLK_PERIOD_PS) - 64'd1) / 64'(CLK_PERIOD_PS));
  localparam int unsigned TURN_OFF_CYCLES   = 1000;

  // ==========================================================================
  // Margin selection
  localparam logic [1:0] MRG_NOMINAL = 2'h0;
  localparam logic [1:0] MRG_HIGH    = 2'h1;
  localparam logic [1:0] MRG_LOW     = 2'h2;

endpackage

// >>> design/slcb_top.sv
// Module: command register bank with busy handshake and supply limit supervision
//
// What this block does
// RL1: Clear not-busy flag during nonvolatile access.
// RL2: Status byte read always acknowledged.
// RL3: While busy, refuse every other command.
// RL4: Word program keeps device busy 0.17ms.
// RL5: Host spaces word writes over 0.17ms.
// RL6: Erase keeps device busy about 400ms.
// RL7: Host polls not-busy flag for handshake.
// RL8: Conversion enabled only above turn-on level.
// RL9: Below turn-off level, disable; immediate or delayed.
// RL10: Compare input against overvoltage fault, warning.
// RL11: Compare input against undervoltage fault, warning.
// RL12: Output format register is read-only.
// RL13: Format mode bits always read zero.
// RL14: Format exponent fixed at minus thirteen.
// RL15: Per-channel servo target register, default 1.0.
// RL16: Ceiling caps every commanded output voltage.
// RL17: Margin high and low setpoints per channel.
// RL18: Supervise output overvoltage fault and warning.
// RL19: Undervoltage fault limit gates power good.
// RL20: Power good on at or above level.
// RL21: Power good off at or below level.
// RL22: Discharge coefficient times target sets off-threshold.
// RL23: Undecayed output: flag, alert, hold channel off.
// RL24: Ten-bit DAC code register, resets zero.
// RL25: DAC upper bits read as zero.
// RL26: Busy ends, flag set, commands acknowledged.
`timescale 1ns/10ps
`default_nettype none

module slcb_top
  import slcb_pkg::*;
#(
  parameter int unsigned WORD_CYCLES  = slcb_pkg::NVM_WORD_CYCLES,
  parameter int unsigned ERASE_CYCLES = slcb_pkg::NVM_ERASE_CYCLES
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        sys_rst,
  // Command port
  input  wire logic                        cmdValid,
  input  wire logic                        cmdWrite,
  input  wire logic [7:0]                  cmdCode,
  input  wire logic [1:0]                  cmdPage,
  input  wire logic [15:0]                 cmdWdata,
  output logic                             rspValid,
  output logic                             rspAck,
  output logic [15:0]                      rspData,
  // Sensed voltages
  input  wire logic [15:0]                 inputSense,
  input  wire logic [slcb_pkg::NUM_CHAN-1:0][15:0] voutSense,
  // Channel control and configuration
  input  wire logic [slcb_pkg::NUM_CHAN-1:0]      chanOnReq,
  input  wire logic [slcb_pkg::NUM_CHAN-1:0][1:0] marginSel,
  input  wire logic                        seqOffMode,
  input  wire logic                        pgoodOffUsesUndervolt,
  input  wire logic                        dischargeClr,
  // Status and drive outputs
  output logic                             nvmBusy,
  output logic                             convEnable,
  output logic [slcb_pkg::NUM_CHAN-1:0]      supplyEnable,
  output logic [slcb_pkg::NUM_CHAN-1:0]      powerGood,
  output logic [slcb_pkg::NUM_CHAN-1:0]      dischargeStatus,
  output logic                             alertOut_n,
  output logic [3:0]                       inputFlags,
  output logic [slcb_pkg::NUM_CHAN-1:0][3:0] outputFlags,
  output logic [slcb_pkg::NUM_CHAN-1:0][15:0] servoTarget,
  output logic [slcb_pkg::NUM_CHAN-1:0][9:0]  dacCode
);
  import slcb_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    logic [NUM_CHAN-1:0][NUM_CREG-1:0][15:0] chanRegs;
    logic [NUM_VREG-1:0][15:0]               vinRegs;
    logic [31:0]                             busyCnt;
    logic                                    busy;
    logic [31:0]                             toffCnt;
    logic                                    convEn;
    logic [NUM_CHAN-1:0]                     supplyEn;
    logic [NUM_CHAN-1:0]                     pgood;
    logic [NUM_CHAN-1:0]                     discharge;
    logic                                    alert_n;
    logic [3:0]                              vinFlags;
    logic [NUM_CHAN-1:0][3:0]                voutFlags;
    logic [NUM_CHAN-1:0][15:0]               target;
    logic [NUM_CHAN-1:0][9:0]                dac;
    logic                                    rspValid;
    logic                                    rspAck;
    logic [15:0]                             rspData;
  } slcb_state_t;

  localparam slcb_state_t RESET_STATE = '{
    chanRegs: {NUM_CHAN{CHAN_RESET}},
    vinRegs:  VIN_RESET,
    alert_n:  1'b1,
    target:   {NUM_CHAN{CHAN_RESET[CI_SETPT]}},
    default:  '0
  };

  slcb_state_t stateQ;
  slcb_state_t stateD;

  // ==========================================================================
  // Helpers
  // Short-float value to signed fixed point, 16 fraction bits
  function automatic logic signed [47:0] shortFloatFixed(input logic [15:0] v);
    logic signed [47:0] m;
    logic [5:0]         sh;
    m  = {{37{v[10]}}, v[10:0]};
    sh = {v[15], v[15:11]} + 6'h10;
    return m <<< sh;
  endfunction

  // Paged command code to register index; valid low when unmapped
  function automatic logic [4:0] chanIndex(input logic [7:0] code);
    logic [4:0] r;
    r = 5'h00;
    unique case (code)
      CMD_SETPOINT:  r = {1'b1, CI_SETPT};
      CMD_CEILING:   r = {1'b1, CI_CEIL};
      CMD_MARGIN_HI: r = {1'b1, CI_MHI};
      CMD_MARGIN_LO: r = {1'b1, CI_MLO};
      CMD_VOUT_OV_F: r = {1'b1, CI_OVF};
      CMD_VOUT_OV_W: r = {1'b1, CI_OVW};
      CMD_VOUT_UV_W: r = {1'b1, CI_UVW};
      CMD_VOUT_UV_F: r = {1'b1, CI_UVF};
      CMD_PG_ON:     r = {1'b1, CI_PGON};
      CMD_PG_OFF:    r = {1'b1, CI_PGOFF};
      CMD_DISCHARGE: r = {1'b1, CI_DISCH};
      CMD_DAC:       r = {1'b1, CI_DAC};
      default:       r = 5'h00;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] vinIndex(input logic [7:0] code);
    logic [3:0] r;
    r = 4'h0;
    unique case (code)
      CMD_TURN_ON_LVL:  r = {1'b1, VI_ON};
      CMD_TURN_OFF_LVL: r = {1'b1, VI_OFF};
      CMD_VIN_OV_F: r = {1'b1, VI_OVF};
      CMD_VIN_OV_W: r = {1'b1, VI_OVW};
      CMD_VIN_UV_W: r = {1'b1, VI_UVW};
      CMD_VIN_UV_F: r = {1'b1, VI_UVF};
      default:      r = 4'h0;
    endcase
    return r;
  endfunction

  // ==========================================================================
  // Per-channel datapath
  logic signed [47:0]             vinFix;
  logic [NUM_CHAN-1:0]            decayed;
  logic [NUM_CHAN-1:0][15:0]      capped;

  assign vinFix = shortFloatFixed(inputSense);

  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic signed [64:0] offThresh;
    logic signed [64:0] voutScaled;
    logic [15:0]        requested;
    assign offThresh  = shortFloatFixed(stateQ.chanRegs[ch][CI_DISCH])
                      * $signed({1'b0, stateQ.chanRegs[ch][CI_SETPT]}); // RL22
    assign voutScaled = $signed({49'h0, voutSense[ch]}) <<< 16;
    assign decayed[ch] = voutScaled < offThresh;
    assign requested = (marginSel[ch] == MRG_HIGH) ? stateQ.chanRegs[ch][CI_MHI] :
                       (marginSel[ch] == MRG_LOW)  ? stateQ.chanRegs[ch][CI_MLO] :
                                                     stateQ.chanRegs[ch][CI_SETPT]; // RL15 RL17
    assign capped[ch] = (requested > stateQ.chanRegs[ch][CI_CEIL]) ?
                        stateQ.chanRegs[ch][CI_CEIL] : requested; // RL16
  end

  // ==========================================================================
  // Next state
  logic [4:0]  cIdx;
  logic [3:0]  vIdx;
  logic        killAll;

  assign cIdx = chanIndex(cmdCode);
  assign vIdx = vinIndex(cmdCode);

  always_comb begin
    stateD = stateQ;
    stateD.rspValid = 1'b0;
    stateD.rspAck   = 1'b0;
    stateD.rspData  = 16'h0000;

    // Busy countdown
    if (stateQ.busyCnt != 32'h0) begin
      stateD.busyCnt = stateQ.busyCnt - 32'h1;
    end
    stateD.busy = (stateD.busyCnt != 32'h0); // RL26

    // Command handling
    if (cmdValid) begin
      stateD.rspValid = 1'b1;
      if (cmdCode == CMD_SHARED_STAT) begin
        stateD.rspAck = 1'b1; // RL2
        if (!cmdWrite) begin
          stateD.rspData[NOT_BUSY_BIT] = ~stateQ.busy; // RL1
        end
      end else if (stateQ.busy) begin
        stateD.rspAck = 1'b0; // RL3
      end else if (cmdCode == CMD_VOUT_FORMAT) begin
        stateD.rspAck  = ~cmdWrite; // RL12
        stateD.rspData = {8'h00, VOUT_FORMAT_VAL}; // RL13 RL14
      end else if (cIdx[4]) begin
        stateD.rspAck = 1'b1;
        if (cmdWrite) begin
          stateD.chanRegs[cmdPage][cIdx[3:0]] = (cIdx[3:0] == CI_DAC) ?
            {6'h00, cmdWdata[DAC_BITS-1:0]} : cmdWdata; // RL24 RL25
        end else begin
          stateD.rspData = stateQ.chanRegs[cmdPage][cIdx[3:0]];
        end
      end else if (vIdx[3]) begin
        stateD.rspAck = 1'b1;
        if (cmdWrite) begin
          stateD.vinRegs[vIdx[2:0]] = cmdWdata;
        end else begin
          stateD.rspData = stateQ.vinRegs[vIdx[2:0]];
        end
      end else if (cmdCode == CMD_NVM_DATA && cmdWrite) begin
        stateD.rspAck  = 1'b1;
        stateD.busyCnt = WORD_CYCLES; // RL4
        stateD.busy    = 1'b1;
      end else if (cmdCode == CMD_NVM_ERASE && cmdWrite) begin
        stateD.rspAck = 1'b1;
        if (cmdWdata[7:0] == ERASE_KEY) begin
          stateD.busyCnt = ERASE_CYCLES; // RL6
          stateD.busy    = 1'b1;
        end
      end else begin
        stateD.rspAck = 1'b0;
      end
    end

    // Input supervision with on/off hysteresis
    if (vinFix > shortFloatFixed(stateQ.vinRegs[VI_ON])) begin
      stateD.convEn = 1'b1; // RL8
    end else if (vinFix < shortFloatFixed(stateQ.vinRegs[VI_OFF])) begin
      stateD.convEn = 1'b0; // RL9
    end
    stateD.vinFlags[3] = vinFix > shortFloatFixed(stateQ.vinRegs[VI_OVF]); // RL10
    stateD.vinFlags[2] = vinFix > shortFloatFixed(stateQ.vinRegs[VI_OVW]); // RL10
    stateD.vinFlags[1] = vinFix < shortFloatFixed(stateQ.vinRegs[VI_UVW]); // RL11
    stateD.vinFlags[0] = vinFix < shortFloatFixed(stateQ.vinRegs[VI_UVF]); // RL11

    // Turn-off delay after conversion drops
    if (stateQ.convEn) begin
      stateD.toffCnt = TURN_OFF_CYCLES;
    end else if (stateQ.toffCnt != 32'h0) begin
      stateD.toffCnt = stateQ.toffCnt - 32'h1;
    end
    killAll = !stateQ.convEn && (!seqOffMode || stateQ.toffCnt == 32'h0); // RL9

    // Channel control and supervision
    for (int ch = 0; ch < NUM_CHAN; ch++) begin
      if (dischargeClr) begin
        stateD.discharge[ch] = 1'b0;
      end
      if (!chanOnReq[ch] || killAll) begin
        stateD.supplyEn[ch] = 1'b0;
      end else if (!stateQ.supplyEn[ch] && stateQ.convEn) begin
        if (decayed[ch]) begin
          stateD.supplyEn[ch] = 1'b1;
        end else begin
          stateD.supplyEn[ch]  = 1'b0; // RL23
          stateD.discharge[ch] = 1'b1; // RL23
        end
      end
      stateD.target[ch] = capped[ch]; // RL16
      stateD.dac[ch]    = stateQ.chanRegs[ch][CI_DAC][DAC_BITS-1:0]; // RL24
      stateD.voutFlags[ch][3] = voutSense[ch] > stateQ.chanRegs[ch][CI_OVF]; // RL18
      stateD.voutFlags[ch][2] = voutSense[ch] > stateQ.chanRegs[ch][CI_OVW]; // RL18
      stateD.voutFlags[ch][1] = voutSense[ch] < stateQ.chanRegs[ch][CI_UVW]; // RL19
      stateD.voutFlags[ch][0] = voutSense[ch] < stateQ.chanRegs[ch][CI_UVF]; // RL19
      if (voutSense[ch] >= stateQ.chanRegs[ch][CI_PGON]) begin
        stateD.pgood[ch] = 1'b1; // RL20
      end else if (pgoodOffUsesUndervolt) begin
        if (voutSense[ch] <= stateQ.chanRegs[ch][CI_UVF]) begin
          stateD.pgood[ch] = 1'b0; // RL19
        end
      end else if (voutSense[ch] <= stateQ.chanRegs[ch][CI_PGOFF]) begin
        stateD.pgood[ch] = 1'b0; // RL21
      end
    end
    stateD.alert_n = ~|stateD.discharge; // RL23
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stateQ <= RESET_STATE;
    end else begin
      stateQ <= stateD;
    end
  end

  // ==========================================================================
  // Outputs
  assign rspValid        = stateQ.rspValid;
  assign rspAck          = stateQ.rspAck;
  assign rspData         = stateQ.rspData;
  assign nvmBusy         = stateQ.busy;
  assign convEnable      = stateQ.convEn;
  assign supplyEnable    = stateQ.supplyEn;
  assign powerGood       = stateQ.pgood;
  assign dischargeStatus = stateQ.discharge;
  assign alertOut_n      = stateQ.alert_n;
  assign inputFlags      = stateQ.vinFlags;
  assign outputFlags     = stateQ.voutFlags;
  assign servoTarget     = stateQ.target;
  assign dacCode         = stateQ.dac;

endmodule

`default_nettype wire

// >>> bench/slcb_chk.sv
// Port-level assertion checker for the limit command bank
`timescale 1ns/10ps
`default_nettype none
module slcb_chk #(
  parameter int unsigned WORD_CYCLES  = 20,
  parameter int unsigned ERASE_CYCLES = 50
) (
  // Clock and reset
  input wire logic                 clk,
  input wire logic                 sys_rst,
  // Command port
  input wire logic                 cmdValid,
  input wire logic                 cmdWrite,
  input wire logic [7:0]           cmdCode,
  input wire logic                 rspValid,
  input wire logic                 rspAck,
  input wire logic [15:0]          rspData,
  // Status and drive
  input wire logic                 nvmBusy,
  input wire logic                 convEnable,
  input wire logic                 seqOffMode,
  input wire logic [slcb_pkg::NUM_CHAN-1:0] supplyEnable
);
  import slcb_pkg::*;
  int unsigned busyLen_q;

  // ==========================================================
  // Busy length counter
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) busyLen_q <= 0;
    else if (nvmBusy) busyLen_q <= busyLen_q + 1;
    else busyLen_q <= 0;
  end

  // ==========================================================
  // Properties
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_answer_one_cycle: assert property (cmdValid |=> rspValid ##1 !rspValid)
    else $error("answer strobe not a single cycle");
  a_status_ack: assert property (cmdValid && cmdCode == CMD_SHARED_STAT |=> rspAck)
    else $error("status access refused");
  a_busy_refuse: assert property (cmdValid && nvmBusy && cmdCode != CMD_SHARED_STAT |=> !rspAck)
    else $error("command acknowledged while busy");
  a_busy_flag_clear: assert property (cmdValid && !cmdWrite && cmdCode == CMD_SHARED_STAT && nvmBusy
    |=> rspData == 16'h0000)
    else $error("not-busy flag set during access");
  a_format_fixed: assert property (cmdValid && !cmdWrite && cmdCode == CMD_VOUT_FORMAT && !nvmBusy
    |=> rspAck && rspData == 16'h0013)
    else $error("format register value wrong");
  a_dac_upper_zero: assert property (cmdValid && !cmdWrite && cmdCode == CMD_DAC |=> rspData[15:10] == 6'h00)
    else $error("dac upper bits not zero");
  a_busy_length: assert property ($fell(nvmBusy) |-> busyLen_q == WORD_CYCLES || busyLen_q == ERASE_CYCLES)
    else $error("busy interval length wrong");
  a_resume_ack: assert property (cmdValid && !nvmBusy && cmdCode == CMD_SETPOINT |=> rspAck)
    else $error("command refused when idle");
  a_supply_drop: assert property ($fell(convEnable) && !seqOffMode |=> supplyEnable == '0)
    else $error("supplies not dropped at once");
endmodule

bind slcb_top slcb_chk #(.WORD_CYCLES(WORD_CYCLES), .ERASE_CYCLES(ERASE_CYCLES)) u_slcb_chk (
  .clk(clk), .sys_rst(sys_rst), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
  .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData), .nvmBusy(nvmBusy),
  .convEnable(convEnable), .seqOffMode(seqOffMode), .supplyEnable(supplyEnable));
`default_nettype wire

// >>> bench/slcb_host.sv
// Host model issuing command reads and writes
`timescale 1ns/10ps
`default_nettype none
module slcb_host (
  // Clock
  input wire logic         clk,
  // Command side
  output var logic         cmdValid,
  output var logic         cmdWrite,
  output var logic [7:0]   cmdCode,
  output var logic [1:0]   cmdPage,
  output var logic [15:0]  cmdWdata,
  // Answer side
  input wire logic         rspValid,
  input wire logic         rspAck,
  input wire logic [15:0]  rspData
);
  import slcb_pkg::*;

  initial begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode  = 8'h00;
    cmdPage  = 2'h0;
    cmdWdata = 16'h0000;
  end

  // One command; answer taken in the cycle it stands
  task automatic xfer(input logic w, input logic [7:0] c, input logic [1:0] p, input logic [15:0] d,
                      output logic a, output logic [15:0] q);
    @(posedge clk);
    #1;
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdCode  = c;
    cmdPage  = p;
    cmdWdata = d;
    @(posedge clk);
    #1;
    cmdValid = 1'b0;
    cmdCode  = ~c;
    cmdWdata = ~d;
    a = rspValid & rspAck;
    q = rspData;
  endtask

  // Handshake by polling the not-busy flag, no fixed delays
  task automatic waitIdle(output logic ok);
    logic a;
    logic [15:0] q;
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++) begin
      xfer(1'b0, CMD_SHARED_STAT, 2'h0, 16'h0000, a, q);
      ok = a & q[NOT_BUSY_BIT];
    end
  endtask
endmodule
`default_nettype wire

// >>> bench/slcb_tb_top.sv
// Self-checking testbench for the limit command bank
`timescale 1ns/10ps
`default_nettype none
module slcb_tb_top;
  import slcb_pkg::*;
  logic clk, sys_rst, cmdValid, cmdWrite, rspValid, rspAck, nvmBusy, convEnable, alertOut_n;
  logic seqOffMode, pgoodOffUsesUndervolt, dischargeClr, ok;
  logic [7:0] cmdCode;
  logic [1:0] cmdPage;
  logic [15:0] cmdWdata, rspData, inputSense;
  logic [3:0] inputFlags, chanOnReq, supplyEnable, powerGood, dischargeStatus;
  logic [NUM_CHAN-1:0][15:0] voutSense, servoTarget;
  logic [NUM_CHAN-1:0][1:0] marginSel;
  logic [NUM_CHAN-1:0][3:0] outputFlags;
  logic [NUM_CHAN-1:0][9:0] dacCode;
  int errors, checksDone;
  logic [23:0] regTab [19] = '{24'h200013, 24'h212000, 24'h248000, 24'h25219A, 24'h261E66, 24'h35D280,
    24'h36D240, 24'h402333, 24'h422266, 24'h431D9A, 24'h441CCD, 24'h55D3C0, 24'h57D380, 24'h588000,
    24'h598000, 24'h5E1EB8, 24'h5F1E14, 24'hE00000, 24'hE9C200};

  slcb_top #(.WORD_CYCLES(20), .ERASE_CYCLES(50)) u_slcb_top (.clk(clk), .sys_rst(sys_rst),
    .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdPage(cmdPage), .cmdWdata(cmdWdata),
    .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData), .inputSense(inputSense), .voutSense(voutSense),
    .chanOnReq(chanOnReq), .marginSel(marginSel), .seqOffMode(seqOffMode),
    .pgoodOffUsesUndervolt(pgoodOffUsesUndervolt), .dischargeClr(dischargeClr), .nvmBusy(nvmBusy),
    .convEnable(convEnable), .supplyEnable(supplyEnable), .powerGood(powerGood),
    .dischargeStatus(dischargeStatus), .alertOut_n(alertOut_n), .inputFlags(inputFlags),
    .outputFlags(outputFlags), .servoTarget(servoTarget), .dacCode(dacCode));
  slcb_host u_slcb_host (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
    .cmdPage(cmdPage), .cmdWdata(cmdWdata), .rspValid(rspValid), .rspAck(rspAck), .rspData(rspData));

  // ==========================================================
  // Helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rd(input logic [7:0] c, input logic [1:0] p, input logic [15:0] e);
    logic a;
    logic [15:0] q;
    u_slcb_host.xfer(1'b0, c, p, 16'h0000, a, q);
    check(16'(a), 16'h0001);
    check(q, e);
  endtask
  task automatic acc(input logic w, input logic [7:0] c, input logic [1:0] p, input logic [15:0] d, input logic e);
    logic a;
    logic [15:0] q;
    u_slcb_host.xfer(w, c, p, d, a, q);
    check(16'(a), 16'(e));
  endtask
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checksDone, errors);
    if (errors == 0 && checksDone > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================
  // Clock, watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    results();
  end

  // ==========================================================
  // Tests
  initial begin
    errors = 0;
    checksDone = 0;
    sys_rst = 1'b1;
    inputSense = 16'h0000;
    voutSense = '0;
    voutSense[2] = 16'h6000;
    chanOnReq = 4'h0;
    marginSel = '0;
    seqOffMode = 1'b0;
    pgoodOffUsesUndervolt = 1'b0;
    dischargeClr = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    foreach (regTab[i]) rd(regTab[i][23:16], 2'h3, regTab[i][15:0]);
    acc(1'b1, 8'h21, 2'h1, 16'h2100, 1'b1);
    rd(8'h21, 2'h1, 16'h2100);
    rd(8'h21, 2'h0, 16'h2000);
    acc(1'b1, 8'h20, 2'h0, 16'h00FF, 1'b0);
    rd(8'h20, 2'h0, 16'h0013);
    acc(1'b1, 8'hE0, 2'h0, 16'hFFFF, 1'b1);
    rd(8'hE0, 2'h0, 16'h03FF);
    check(16'(dacCode[0]), 16'h03FF);
    acc(1'b1, 8'h24, 2'h1, 16'h1000, 1'b1);
    marginSel[1] = 2'h2;
    settle();
    check(servoTarget[1], 16'h1000);
    check(servoTarget[0], 16'h2000);
    acc(1'b1, 8'h24, 2'h1, 16'h8000, 1'b1);
    marginSel[0] = 2'h1;
    settle();
    check(servoTarget[0], 16'h219A);
    check(servoTarget[1], 16'h1E66);
    acc(1'b1, CMD_NVM_DATA, 2'h0, 16'h1234, 1'b1);
    rd(CMD_SHARED_STAT, 2'h0, 16'h0000);
    acc(1'b0, 8'h21, 2'h1, 16'h0000, 1'b0);
    acc(1'b1, 8'h21, 2'h1, 16'h0555, 1'b0);
    u_slcb_host.waitIdle(ok);
    check(16'(ok), 16'h0001);
    rd(8'h21, 2'h1, 16'h2100);
    acc(1'b1, CMD_NVM_ERASE, 2'h0, 16'h002B, 1'b1);
    rd(CMD_SHARED_STAT, 2'h0, 16'h0000);
    u_slcb_host.waitIdle(ok);
    check(16'(ok), 16'h0001);
    acc(1'b1, CMD_NVM_ERASE, 2'h0, 16'h0011, 1'b1);
    rd(CMD_SHARED_STAT, 2'h0, 16'h0040);
    inputSense = 16'hD2C0;
    acc(1'b1, 8'h58, 2'h0, 16'hD300, 1'b1);
    settle();
    check(16'(convEnable), 16'h0001);
    check(16'(inputFlags), 16'h0002);
    inputSense = 16'hD3E0;
    settle();
    check(16'(inputFlags), 16'h000C);
    inputSense = 16'hD2C0;
    chanOnReq = 4'h5;
    settle();
    check(16'(supplyEnable), 16'h0001);
    check(16'(dischargeStatus), 16'h0004);
    check(16'(alertOut_n), 16'h0000);
    voutSense[2] = 16'h0000;
    dischargeClr = 1'b1;
    settle();
    dischargeClr = 1'b0;
    voutSense[0] = 16'h1EB8;
    voutSense[1] = 16'h2400;
    voutSense[3] = 16'h1C00;
    settle();
    check(16'(supplyEnable), 16'h0005);
    check(16'(alertOut_n), 16'h0001);
    check(16'(powerGood[0]), 16'h0001);
    check(16'(outputFlags[1]), 16'h000C);
    check(16'(outputFlags[3]), 16'h0003);
    voutSense[0] = 16'h1E80;
    settle();
    check(16'(powerGood[0]), 16'h0001);
    voutSense[0] = 16'h1E14;
    settle();
    check(16'(powerGood[0]), 16'h0000);
    voutSense[0] = 16'h1EB8;
    settle();
    pgoodOffUsesUndervolt = 1'b1;
    voutSense[0] = 16'h1E00;
    settle();
    check(16'(powerGood[0]), 16'h0001);
    voutSense[0] = 16'h1C00;
    settle();
    check(16'(powerGood[0]), 16'h0000);
    seqOffMode = 1'b1;
    inputSense = 16'hD200;
    settle();
    check(16'(convEnable), 16'h0000);
    check(16'(supplyEnable), 16'h0005);
    repeat (1000) @(posedge clk);
    settle();
    check(16'(supplyEnable), 16'h0000);
    seqOffMode = 1'b0;
    inputSense = 16'hD2C0;
    settle();
    check(16'(supplyEnable), 16'h0005);
    inputSense = 16'hD200;
    settle();
    check(16'(supplyEnable), 16'h0000);
    results();
  end
endmodule
`default_nettype wire
